/* File: gltc_ctrl_model.sv */
`timescale 1ns/1ns
// ------------
// controller and guard mechanics model
// ------------
module gltc_ctrl_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// bench commands
	input wire logic energise_to_lock,
	input wire logic want_lock,
	input wire logic guard_closed,
	// device side
	input wire logic lock_drive,
	input wire logic safety_output_a,
	input wire logic safety_output_b,
	output logic lock_request,
	output logic guard_locked,
	output logic outputs_valid
);
	assign outputs_valid = safety_output_a & safety_output_b;
	// bolt takes a cycle to travel, and an open guard cannot be bolted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_request <= 1'b0;
			guard_locked <= 1'b0;
		end else begin
			lock_request <= energise_to_lock ? want_lock : !want_lock;
			guard_locked <= guard_closed & lock_drive;
		end
	end
endmodule // gltc_ctrl_model

/* File: gltc_guard_lock.sv */
// Behaviour
// RQ1 - standard coded unit accepts its actuator at once, no teaching needed
// RQ2 - new actuator after power-up enters teach: power off, fault on, status 1 Hz
// RQ3 - after 10 s of teaching status switches to short 3 Hz flashes
// RQ4 - no power removal within 5 min aborts teach with five fault flashes
// RQ5 - taught code becomes active only when actuator is seen after power returns
// RQ6 - single teach variant keeps its first pairing and refuses later teaching
// RQ7 - multi teach variant may teach again, new code replaces the old one
// RQ8 - multi teach variant holds safety outputs off ten minutes after teaching
// RQ9 - power indicator blinks until inhibit expired and new actuator detected
// RQ10 - supply loss during inhibit restarts the whole interval on return
// RQ11 - energise-to-release: request high unlocks, request low keeps locked
// RQ12 - energise-to-lock: request high locks, request low keeps released
// RQ13 - lock monitoring drops both safety outputs as soon as guard unlocks
// RQ14 - lock monitoring re-enables outputs on relock with actuator still inserted
// RQ15 - guard monitoring drops safety outputs only when the guard opens
// RQ16 - both safety outputs stay off for the whole teach sequence
// RQ17 - controller drives the request per polarity and trusts only both outputs
`timescale 1ns/1ns
module gltc_guard_lock #(
	parameter int MS_CYCLES = gltc_pkg::MS_CYC,
	parameter int TEACH_CNT = gltc_pkg::TEACH_MS,
	parameter int POWREQ_CNT = gltc_pkg::POWREQ_MS,
	parameter int INHIBIT_CNT = gltc_pkg::INHIBIT_MS,
	parameter int CODE_W = gltc_pkg::CODE_W
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// supply, actuator and guard sensing
	input wire logic supply_ok,
	input wire logic actuator_detect,
	input wire logic [CODE_W-1:0] actuator_code,
	input wire logic guard_closed,
	input wire logic guard_locked,
	input wire logic lock_request,
	// safety outputs, solenoid, indicators
	output logic safety_output_a,
	output logic safety_output_b,
	output logic lock_drive,
	output logic led_power,
	output logic led_fault,
	output logic led_status,
	output logic irq
);
	// ----------------------------------------------------------------
	// state and storage
	// ----------------------------------------------------------------
	gltc_pkg::gltc_state_t state_q, state_d;
	gltc_pkg::gltc_ctrl_t ctrl_q;
	logic [gltc_pkg::EV_W-1:0] int_stat_q, int_mask_q, ev;
	logic [CODE_W-1:0] code_q, pend_q;
	logic code_valid_q, pend_ok_q, fresh_q, inhibit_q, inhib_led_q;
	logic [15:0] pre_q;
	logic [gltc_pkg::MS_W-1:0] ms_q, inh_q, blk_q, fst_q;

	function automatic logic [gltc_pkg::MS_W-1:0] ms(input int v);
		ms = gltc_pkg::MS_W'(v);
	endfunction

	// ----------------------------------------------------------------
	// decode of conditions
	// ----------------------------------------------------------------
	wire single_teach_variant = ~ctrl_q.multi_teach_variant;
	wire multi_teach_variant = ctrl_q.multi_teach_variant;
	wire tick = (pre_q == 16'(MS_CYCLES - 1));
	wire state_chg = (state_d != state_q);
	wire code_match = code_valid_q & (actuator_code == code_q);
	// RQ1 standard coding accepts
	wire accepted = actuator_detect & (~ctrl_q.individual_coding | code_match);
	wire new_act = fresh_q & ctrl_q.individual_coding & actuator_detect & ~code_match;
	// RQ6 single pairing is final
	wire refuse = new_act & single_teach_variant & code_valid_q;
	wire teach_go = new_act & ~refuse;
	wire arm_match = (state_q == gltc_pkg::ST_ARM) & actuator_detect & (actuator_code == pend_q);
	wire inh_done = inhibit_q & tick & (inh_q == ms(INHIBIT_CNT - 1));
	// RQ11 release polarity
	// RQ12 lock polarity
	wire lock_cmd = ctrl_q.energise_to_lock ? lock_request : ~lock_request;
	// RQ13 lock monitoring
	// RQ14 relock re-enables
	// RQ15 guard monitoring
	wire guard_ok = guard_closed & (ctrl_q.guard_monitoring | (guard_locked & lock_cmd));
	// RQ8 inhibit blocks outputs
	// RQ16 off while teaching
	wire out_d = (state_q == gltc_pkg::ST_RUN) & accepted & ~inhibit_q & guard_ok;
	wire slow_on = blk_q < ms(gltc_pkg::SLOW_PERIOD_MS / 2);
	wire fast_on = fst_q < ms(gltc_pkg::FAST_ON_MS);

	// ----------------------------------------------------------------
	// teach sequence
	// ----------------------------------------------------------------
	// next state; supply loss always wins
	always_comb begin
		state_d = state_q;
		case (state_q)
			gltc_pkg::ST_OFF: begin
				if (supply_ok)
					state_d = pend_ok_q ? gltc_pkg::ST_ARM : gltc_pkg::ST_RUN;
			end
			gltc_pkg::ST_RUN: begin
				// RQ2 enter teach
				if (teach_go)
					state_d = gltc_pkg::ST_TEACH;
				else if (refuse)
					state_d = gltc_pkg::ST_ABORT;
			end
			gltc_pkg::ST_TEACH: begin
				// RQ3 ask for power off
				if (tick && ms_q == ms(TEACH_CNT - 1))
					state_d = gltc_pkg::ST_POWREQ;
			end
			gltc_pkg::ST_POWREQ: begin
				// RQ4 power not removed
				if (tick && ms_q == ms(POWREQ_CNT - 1))
					state_d = gltc_pkg::ST_ABORT;
			end
			gltc_pkg::ST_ARM: begin
				if (actuator_detect)
					state_d = gltc_pkg::ST_RUN;
			end
			default: state_d = state_q;
		endcase
		if (!supply_ok)
			state_d = gltc_pkg::ST_OFF;
	end

	// state register and the millisecond timebase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= gltc_pkg::ST_OFF;
			pre_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			pre_q <= tick ? 16'h0000 : pre_q + 16'h0001;
		end
	end

	// phase timers restart on every state change so blinks start aligned
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_q <= '0;
			blk_q <= '0;
			fst_q <= '0;
		end else if (state_chg) begin
			ms_q <= '0;
			blk_q <= '0;
			fst_q <= '0;
		end else if (tick) begin
			// saturate at full scale so the abort flash window never wraps
			ms_q <= (ms_q == '1) ? ms_q : ms_q + ms(1);
			blk_q <= (blk_q == ms(gltc_pkg::SLOW_PERIOD_MS - 1)) ? '0 : blk_q + ms(1);
			fst_q <= (fst_q == ms(gltc_pkg::FAST_PERIOD_MS - 1)) ? '0 : fst_q + ms(1);
		end
	end

	// pending code and power-up bookkeeping; only a power drop in the
	// power-off request phase arms the pending code, which stays armed until the actuator is seen in ARM
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_q <= '0;
			pend_ok_q <= 1'b0;
			fresh_q <= 1'b0;
		end else begin
			if (state_q == gltc_pkg::ST_RUN && teach_go)
				pend_q <= actuator_code;
			if (state_q == gltc_pkg::ST_POWREQ && !supply_ok)
				pend_ok_q <= 1'b1;
			else if (state_q == gltc_pkg::ST_ARM && actuator_detect)
				pend_ok_q <= 1'b0;
			if (state_q == gltc_pkg::ST_OFF)
				fresh_q <= 1'b1;
			else if (state_q == gltc_pkg::ST_RUN && actuator_detect)
				fresh_q <= 1'b0;
		end
	end

	// stored code survives supply loss, only the chip reset clears it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			code_q <= '0;
			code_valid_q <= 1'b0;
		// RQ5 activate on redetect
		// RQ7 new code replaces old
		end else if (arm_match) begin
			code_q <= pend_q;
			code_valid_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// enable inhibit
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			inhibit_q <= 1'b0;
			inh_q <= '0;
			inhib_led_q <= 1'b0;
		end else begin
			// RQ8 ten minute inhibit
			if (arm_match && multi_teach_variant) begin
				inhibit_q <= 1'b1;
				inh_q <= '0;
			// RQ10 restart after power loss
			end else if (!supply_ok) begin
				inh_q <= '0;
			end else if (inh_done) begin
				inhibit_q <= 1'b0;
			end else if (inhibit_q && tick) begin
				inh_q <= inh_q + ms(1);
			end
			// RQ9 green blink end
			if (arm_match && multi_teach_variant)
				inhib_led_q <= 1'b1;
			else if (!inhibit_q && accepted && supply_ok)
				inhib_led_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// outputs: safety channels, solenoid, indicators
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			safety_output_a <= 1'b0;
			safety_output_b <= 1'b0;
			lock_drive <= 1'b0;
		end else begin
			safety_output_a <= out_d;
			safety_output_b <= out_d;
			lock_drive <= supply_ok & lock_cmd;
		end
	end

	// indicator patterns per state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			led_power <= 1'b0;
			led_fault <= 1'b0;
			led_status <= 1'b0;
		end else begin
			case (state_q)
				// RQ2 teach signalling
				gltc_pkg::ST_TEACH: begin
					led_power <= 1'b0;
					led_fault <= 1'b1;
					led_status <= slow_on;
				end
				// RQ3 short fast flashes
				gltc_pkg::ST_POWREQ: begin
					led_power <= 1'b0;
					led_fault <= 1'b1;
					led_status <= fast_on;
				end
				// RQ4 five fault flashes
				gltc_pkg::ST_ABORT: begin
					led_power <= 1'b1;
					led_fault <= (ms_q < ms(gltc_pkg::ABORT_MS)) & slow_on;
					led_status <= 1'b0;
				end
				gltc_pkg::ST_RUN, gltc_pkg::ST_ARM: begin
					led_power <= inhib_led_q ? slow_on : 1'b1;
					led_fault <= 1'b0;
					led_status <= out_d | (guard_closed & slow_on);
				end
				default: begin
					led_power <= 1'b0;
					led_fault <= 1'b0;
					led_status <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// apb registers and interrupt
	// ----------------------------------------------------------------
	wire setup = psel & ~penable;
	wire acc = psel & penable & pready;
	wire sel_ctrl = (paddr == gltc_pkg::OFF_CTRL);
	wire sel_stat = (paddr == gltc_pkg::OFF_STATUS);
	wire sel_ist = (paddr == gltc_pkg::OFF_INT_STAT);
	wire sel_imsk = (paddr == gltc_pkg::OFF_INT_MASK);
	wire sel_code = (paddr == gltc_pkg::OFF_CODE);
	wire mapped = sel_ctrl | sel_stat | sel_ist | sel_imsk | sel_code;
	wire [31:0] status_w = {24'h000000, lock_drive, safety_output_a, inhibit_q, code_valid_q, 1'b0, state_q};
	wire [31:0] rd_w = sel_ctrl ? {28'h0000000, ctrl_q} :
		sel_stat ? status_w :
		sel_ist ? {26'h0, int_stat_q} :
		sel_imsk ? {26'h0, int_mask_q} :
		sel_code ? 32'(code_q) : 32'h00000000;
	wire rd_clr = acc & ~pwrite & sel_ist;

	// events that set the sticky status bits
	always_comb begin
		ev = '0;
		ev[gltc_pkg::EV_TEACH] = state_chg & (state_d == gltc_pkg::ST_TEACH);
		ev[gltc_pkg::EV_POWREQ] = state_chg & (state_d == gltc_pkg::ST_POWREQ);
		ev[gltc_pkg::EV_ABORT] = state_chg & (state_d == gltc_pkg::ST_ABORT);
		ev[gltc_pkg::EV_STORED] = arm_match;
		ev[gltc_pkg::EV_INHIB_END] = inh_done & supply_ok;
		ev[gltc_pkg::EV_OUT_OFF] = safety_output_a & ~out_d;
	end

	// no wait state: answer is prepared in setup, taken in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setup;
			pslverr <= setup & ~mapped;
			prdata <= (setup && !pwrite) ? rd_w : 32'h00000000;
		end
	end

	// writable registers; a new event wins over a read clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= gltc_pkg::CTRL_RST;
			int_mask_q <= gltc_pkg::INT_MASK_RST;
			int_stat_q <= '0;
			irq <= 1'b0;
		end else begin
			if (acc && pwrite && sel_ctrl)
				ctrl_q <= pwdata[3:0];
			if (acc && pwrite && sel_imsk)
				int_mask_q <= pwdata[gltc_pkg::EV_W-1:0];
			int_stat_q <= (rd_clr ? '0 : int_stat_q) | ev;
			irq <= |(int_stat_q & int_mask_q);
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	outs_teach_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ16
		(state_q == gltc_pkg::ST_TEACH || state_q == gltc_pkg::ST_POWREQ) |=> !safety_output_a && !safety_output_b)
		else $error("safety output on during teach");
	outs_inhibit_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
		inhibit_q |=> !safety_output_a)
		else $error("safety output on during inhibit");
	teach_leds_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
		state_q == gltc_pkg::ST_TEACH |=> !led_power && led_fault)
		else $error("teach indicators wrong");
	teach_time_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
		(state_q == gltc_pkg::ST_TEACH && supply_ok && tick && ms_q == ms(TEACH_CNT - 1))
		|=> state_q == gltc_pkg::ST_POWREQ)
		else $error("no power-off request after teach time");
	single_ref_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
		(state_q == gltc_pkg::ST_RUN && code_valid_q && single_teach_variant) |=> state_q != gltc_pkg::ST_TEACH)
		else $error("single variant taught again");
	code_store_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
		arm_match |=> code_valid_q && code_q == $past(pend_q))
		else $error("taught code not stored");
	lock_pol_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
		supply_ok && ctrl_q.energise_to_lock |=> lock_drive == $past(lock_request))
		else $error("lock polarity wrong");
	guard_mon_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ15
		!guard_closed |=> !safety_output_a && !safety_output_b)
		else $error("outputs on with guard open");
	lock_mon_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
		!ctrl_q.guard_monitoring && !guard_locked |=> !safety_output_a)
		else $error("outputs on while unlocked");
	inh_restart_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
		inhibit_q && !supply_ok |=> inh_q == '0)
		else $error("inhibit not restarted");
endmodule // gltc_guard_lock

/* File: gltc_guard_lock_tb.sv */
`timescale 1ns/1ns
module gltc_guard_lock_tb;
	// short counts keep the run small; the slow blink period still spans 4000 ticks
	localparam int MSC = 4;
	localparam int TCH = 10;
	localparam int PWR = 30;
	localparam int INH = 20;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, lock_request, guard_locked, outputs_valid;
	logic supply_ok = 1'b0;
	logic actuator_detect = 1'b0;
	logic [7:0] actuator_code = 8'h5A;
	logic guard_closed = 1'b0;
	logic want_lock = 1'b0;
	logic etl = 1'b0;
	logic safety_output_a, safety_output_b, lock_drive, led_power, led_fault, led_status, irq;
	int miscompares = 0;
	int checks_done = 0;
	int n;
	logic prev;
	logic [31:0] d;
	logic e;
	// ------------
	// clock, design and partner
	// ------------
	always #20 pclk = ~pclk;
	gltc_guard_lock #(.MS_CYCLES(MSC), .TEACH_CNT(TCH), .POWREQ_CNT(PWR), .INHIBIT_CNT(INH), .CODE_W(8)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .supply_ok(supply_ok),
		.actuator_detect(actuator_detect), .actuator_code(actuator_code), .guard_closed(guard_closed),
		.guard_locked(guard_locked), .lock_request(lock_request), .safety_output_a(safety_output_a),
		.safety_output_b(safety_output_b), .lock_drive(lock_drive), .led_power(led_power),
		.led_fault(led_fault), .led_status(led_status), .irq(irq));
	gltc_ctrl_model ctrl (.pclk(pclk), .presetn(presetn), .energise_to_lock(etl), .want_lock(want_lock),
		.guard_closed(guard_closed), .lock_drive(lock_drive), .safety_output_a(safety_output_a),
		.safety_output_b(safety_output_b), .lock_request(lock_request), .guard_locked(guard_locked),
		.outputs_valid(outputs_valid));
	// ------------
	// tasks
	// ------------
	task automatic finish_test();
		$display("compares %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge pclk);
	endtask
	task automatic ms(input int t);
		tick(t * MSC);
	endtask
	// one apb transfer; the request stands until pready is seen
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		int w;
		w = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			w++;
		end while (pready !== 1'b1 && w < 16);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (w >= 16) chk(32'h0, 32'h1, "apb answer");
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] x;
		logic y;
		apb(1'b1, a, wd, x, y);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string what);
		logic [31:0] x;
		logic y;
		apb(1'b0, a, 32'h0, x, y);
		chk(x & m, exp, what);
	endtask
	task automatic st(input logic [2:0] s);
		rd(gltc_pkg::OFF_STATUS, 32'h7, {29'h0, s}, "state");
	endtask
	task automatic safe(input logic v);
		chk({29'h0, outputs_valid, safety_output_a, safety_output_b}, {29'h0, v, v, v}, "safety outputs");
	endtask
	// ------------
	// watchdog and tests
	// ------------
	initial begin
		tick(60000);
		miscompares++;
		$display("Error at %0t: watchdog expired", $time);
		finish_test();
	end
	initial begin
		tick(20);
		presetn <= 1'b1;
		rd(gltc_pkg::OFF_CTRL, 32'hF, 32'h0, "ctrl reset");
		rd(gltc_pkg::OFF_INT_MASK, 32'h3F, 32'h0, "mask reset");
		apb(1'b0, 8'h14, 32'h0, d, e);
		chk({31'h0, e}, 32'h1, "unmapped error");
		chk(d, 32'h0, "unmapped data");
		wr(gltc_pkg::OFF_CTRL, 32'hF);
		rd(gltc_pkg::OFF_CTRL, 32'hFFFFFFFF, 32'hF, "ctrl readback");
		wr(gltc_pkg::OFF_CTRL, 32'h0);
		$display("test registers done");
		supply_ok <= 1'b1;
		guard_closed <= 1'b1;
		actuator_detect <= 1'b1;
		want_lock <= 1'b1;
		tick(8);
		st(3'd1);
		safe(1'b1);
		chk({31'h0, lock_drive}, 32'h1, "locked at low request");
		want_lock <= 1'b0;
		tick(6);
		chk({31'h0, lock_drive}, 32'h0, "released at high request");
		safe(1'b0);
		want_lock <= 1'b1;
		tick(6);
		safe(1'b1);
		wr(gltc_pkg::OFF_CTRL, 32'hC);
		etl <= 1'b1;
		tick(6);
		chk({31'h0, lock_drive}, 32'h1, "locked at high request");
		want_lock <= 1'b0;
		tick(6);
		chk({31'h0, lock_drive}, 32'h0, "released at low request");
		safe(1'b1);
		guard_closed <= 1'b0;
		tick(6);
		safe(1'b0);
		guard_closed <= 1'b1;
		want_lock <= 1'b1;
		etl <= 1'b0;
		wr(gltc_pkg::OFF_CTRL, 32'h1);
		$display("test lock modes done");
		actuator_detect <= 1'b0;
		wr(gltc_pkg::OFF_INT_MASK, 32'h1 << gltc_pkg::EV_TEACH);
		supply_ok <= 1'b0;
		tick(4);
		supply_ok <= 1'b1;
		tick(4);
		actuator_detect <= 1'b1;
		tick(4);
		st(3'd2);
		chk({29'h0, led_power, led_fault, led_status}, 32'h3, "teach lamps");
		safe(1'b0);
		chk({31'h0, irq}, 32'h1, "teach irq");
		rd(gltc_pkg::OFF_INT_STAT, 32'h1, 32'h1, "teach event");
		tick(3);
		chk({31'h0, irq}, 32'h0, "irq cleared");
		rd(gltc_pkg::OFF_INT_STAT, 32'h1, 32'h0, "event cleared");
		ms(TCH);
		st(3'd3);
		safe(1'b0);
		supply_ok <= 1'b0;
		actuator_detect <= 1'b0;
		tick(4);
		st(3'd0);
		supply_ok <= 1'b1;
		tick(6);
		st(3'd5);
		rd(gltc_pkg::OFF_STATUS, 32'h10, 32'h0, "no code yet");
		actuator_detect <= 1'b1;
		tick(8);
		st(3'd1);
		rd(gltc_pkg::OFF_CODE, 32'hFF, 32'h5A, "stored code");
		safe(1'b1);
		actuator_code <= 8'hA5;
		supply_ok <= 1'b0;
		tick(4);
		supply_ok <= 1'b1;
		tick(6);
		st(3'd4);
		safe(1'b0);
		rd(gltc_pkg::OFF_CODE, 32'hFF, 32'h5A, "code kept");
		$display("test single teach done");
		wr(gltc_pkg::OFF_CTRL, 32'h3);
		supply_ok <= 1'b0;
		tick(4);
		supply_ok <= 1'b1;
		tick(4);
		st(3'd2);
		ms(TCH + 2);
		st(3'd3);
		ms(PWR - 10);
		st(3'd3);
		ms(8);
		st(3'd4);
		rd(gltc_pkg::OFF_INT_STAT, 32'h4, 32'h4, "abort event");
		n = 0;
		prev = 1'b0;
		repeat (6000 * MSC) begin
			@(posedge pclk);
			if (led_fault === 1'b1 && prev !== 1'b1) n++;
			prev = led_fault;
		end
		chk(32'(n), 32'(gltc_pkg::ABORT_FLASHES), "fault flashes");
		$display("test abort done");
		supply_ok <= 1'b0;
		tick(4);
		supply_ok <= 1'b1;
		tick(4);
		ms(TCH + 1);
		st(3'd3);
		supply_ok <= 1'b0;
		actuator_detect <= 1'b0;
		tick(4);
		supply_ok <= 1'b1;
		tick(4);
		actuator_detect <= 1'b1;
		tick(6);
		rd(gltc_pkg::OFF_CODE, 32'hFF, 32'hA5, "new code");
		rd(gltc_pkg::OFF_STATUS, 32'h20, 32'h20, "inhibit on");
		safe(1'b0);
		ms(INH / 2);
		supply_ok <= 1'b0;
		tick(4);
		supply_ok <= 1'b1;
		ms(INH - 4);
		safe(1'b0);
		ms(6);
		safe(1'b1);
		chk({31'h0, led_power}, 32'h1, "power lamp steady");
		$display("test multi teach done");
		finish_test();
	end
endmodule // gltc_guard_lock_tb

/* File: gltc_pkg.sv */
// ----------------------------------------------------------------
// guard lock teach control constants
// ----------------------------------------------------------------
package gltc_pkg;
	// clock and time figures
	localparam int CLK_HZ = 25_000_000;
	localparam int MS_CYC = CLK_HZ / 1000;
	localparam int TEACH_WAIT_S = 10;
	localparam int POWREQ_MIN = 5;
	localparam int INHIBIT_MIN = 10;
	localparam int SLOW_HZ = 1;
	localparam int FAST_HZ = 3;
	localparam int FAST_ON_MS = 50;
	localparam int ABORT_FLASHES = 5;
	localparam int TEACH_MS = TEACH_WAIT_S * 1000;
	localparam int POWREQ_MS = POWREQ_MIN * 60 * 1000;
	localparam int INHIBIT_MS = INHIBIT_MIN * 60 * 1000;
	localparam int SLOW_PERIOD_MS = 1000 / SLOW_HZ;
	localparam int FAST_PERIOD_MS = 1000 / FAST_HZ;
	localparam int ABORT_MS = ABORT_FLASHES * SLOW_PERIOD_MS;
	localparam int MS_W = 20;
	localparam int CODE_W = 8;
	// register offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_INT_STAT = 8'h08;
	localparam logic [7:0] OFF_INT_MASK = 8'h0C;
	localparam logic [7:0] OFF_CODE = 8'h10;
	// interrupt event bits
	localparam int EV_TEACH = 0;
	localparam int EV_POWREQ = 1;
	localparam int EV_ABORT = 2;
	localparam int EV_STORED = 3;
	localparam int EV_INHIB_END = 4;
	localparam int EV_OUT_OFF = 5;
	localparam int EV_W = 6;
	localparam logic [5:0] INT_MASK_RST = 6'h00;
	// control register layout, bit 0 is individual_coding
	typedef struct packed {
		logic guard_monitoring;
		logic energise_to_lock;
		logic multi_teach_variant;
		logic individual_coding;
	} gltc_ctrl_t;
	localparam logic [3:0] CTRL_RST = 4'h0;
	typedef enum logic [2:0] {ST_OFF, ST_RUN, ST_TEACH, ST_POWREQ, ST_ABORT, ST_ARM} gltc_state_t;
endpackage
